// file: hw/sesp_dev.sv
// serial eeprom device end: bit framing, addressing, page buffer and program cycle
// Summary of operation
// (R1) sample data on scl rise, launch on fall
// (R2) data pin open drain: pull low or release
// (R3) small variant matches two strap bits
// (R4) large variant matches upper strap only
// (R5) write guard high blocks all array writes
// (R6) small: 32 pages of 16, 9-bit address
// (R7) large: 64 pages of 16, 10-bit address
// (R8) data changes only while clock low
// (R9) start opens every command, device restarts reception
// (R10) stop ends transfer; after read, standby
// (R11) 8-bit words, acknowledged low on ninth clock
// (R12) standby at reset and after stop
// (R13) start, nine clocks, start, stop recovers bus
// (R14) program cycle starts at stop, within 5ms
// (R15) page writes up to 16 bytes, partial allowed
// (R16) master sends zero straps for five-lead part
// (R17) master keeps scl at 400kHz or 1MHz
// (R18) device word: 1010, straps/page, read/write bit
// (R19) match acknowledges zero; mismatch returns to standby
// (R20) program cycle ignores bus, no acknowledge
// (R21) polling acknowledged only after program completes
// (R22) data released except ack and read bits
`timescale 1ns/100ps
`default_nettype none

module sesp_fifo #(
  parameter int W = sesp_pkg::FIFO_W,
  parameter int D = sesp_pkg::FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] store [0:D-1];
  logic [AW:0]  wp;
  logic [AW:0]  rp;

  assign in_ready  = (wp - rp) != (AW+1)'(D);
  assign out_valid = wp != rp;
  assign out_data  = store[rp[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      store[wp[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp <= wp + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule // sesp_fifo

module sesp_dev
  import sesp_pkg::*;
#(
  parameter bit LARGE      = 1'b0,
  parameter int TWR_CYCLES = TWR_CYC
) (
  input  wire logic clk,
  input  wire logic srst,
  sesp_if.dev       bus,
  input  wire logic strap_select_upper,
  input  wire logic strap_select_lower,
  input  wire logic unused_strap_input,
  input  wire logic write_guard
);
  typedef enum logic [5:0] {
    D_STBY = 6'h01,
    D_RX   = 6'h02,
    D_ACK  = 6'h04,
    D_TX   = 6'h08,
    D_RACK = 6'h10,
    D_PROG = 6'h20
  } sesp_dst_t;
  typedef enum logic [2:0] {
    K_DEV   = 3'h1,
    K_WADDR = 3'h2,
    K_DATA  = 3'h4
  } sesp_kind_t;

  logic [7:0]        mem [0:MEM_BYTES-1];
  logic [4:0]        s1;
  logic [4:0]        s2;
  logic [4:0]        s3;
  logic [4:0]        lvl;
  logic [4:0]        next_lvl;
  sesp_dst_t         st;
  sesp_kind_t        kind;
  logic [3:0]        cnt;
  logic [7:0]        shreg;
  logic              rw;
  logic              mack;
  logic              wr_pend;
  logic [1:0]        pg;
  logic [ADDR_W-1:0] addr;
  logic [20:0]       tmr;
  logic              tmr_done;
  logic              scl_rise;
  logic              scl_fall;
  logic              start;
  logic              stop;
  logic              byte_done;
  logic              dev_hit;
  logic              f_iready;
  logic              f_ovalid;
  logic              push;
  logic [FIFO_W-1:0] f_odata;
  logic [7:0]        rd_byte;
  logic [ADDR_W-1:0] amask;

  // straps sit on the same 3-stage path as the bus pins; unused strap is ignored
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= SYNC_RST;
      s2 <= SYNC_RST;
      s3 <= SYNC_RST;
    end else begin
      s1 <= {write_guard, strap_select_lower, strap_select_upper, bus.scl, bus.sda};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a level only changes once stages two and three agree
  assign next_lvl = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl);

  always_ff @(posedge clk) begin
    if (srst) begin
      lvl <= SYNC_RST;
    end else begin
      lvl <= next_lvl;
    end
  end

  assign scl_rise  = next_lvl[1] && !lvl[1];
  assign scl_fall  = !next_lvl[1] && lvl[1];
  assign start     = lvl[1] && next_lvl[1] && lvl[0] && !next_lvl[0]; // R9 R8
  assign stop      = lvl[1] && next_lvl[1] && !lvl[0] && next_lvl[0]; // R10 R8
  assign byte_done = (st == D_RX) && scl_fall && (cnt == BIT_LAST);   // R11
  assign amask     = LARGE ? AMASK_LARGE : AMASK_SMALL;               // R6 R7
  assign rd_byte   = mem[addr];
  assign tmr_done  = tmr >= 21'(TWR_CYCLES - 1);

  always_comb begin
    dev_hit = (shreg[7:4] == DEV_CODE) && (shreg[3] == lvl[2]); // R18 R4
    if (!LARGE) begin
      dev_hit = dev_hit && (shreg[2] == lvl[3]); // R3
    end
  end

  // data enters on rising scl
  always_ff @(posedge clk) begin
    if (srst) begin
      shreg <= '0;
    end else if (scl_rise) begin
      shreg <= {shreg[6:0], lvl[0]}; // R1
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st   <= D_STBY; // R12
      kind <= K_DEV;
      cnt  <= '0;
      rw   <= 1'b0;
      mack <= 1'b0;
      bus.sda_dev_oe <= 1'b0;
    end else if (st == D_PROG) begin
      bus.sda_dev_oe <= 1'b0; // R20 R21
      if (tmr_done && !f_ovalid) begin
        st <= D_STBY; // R12
      end
    end else if (start) begin
      st   <= D_RX; // R9 R13
      kind <= K_DEV;
      cnt  <= '0;
      bus.sda_dev_oe <= 1'b0;
    end else if (stop) begin
      bus.sda_dev_oe <= 1'b0;
      st <= wr_pend ? D_PROG : D_STBY; // R14 R10 R12
    end else begin
      unique case (st)
        D_STBY: begin
          bus.sda_dev_oe <= 1'b0;
        end
        D_RX: begin
          if (scl_rise) begin
            cnt <= cnt + 1'b1;
          end else if (byte_done) begin
            cnt <= '0;
            unique case (kind)
              K_DEV: begin
                if (dev_hit) begin
                  bus.sda_dev_oe <= 1'b1; // R19 R11
                  rw <= shreg[0];         // R18
                  st <= D_ACK;
                end else begin
                  st <= D_STBY; // R19
                end
              end
              K_WADDR: begin
                bus.sda_dev_oe <= 1'b1; // R11
                st <= D_ACK;
              end
              K_DATA: begin
                // a full buffer refuses the byte rather than lose it
                if (f_iready || lvl[4]) begin
                  bus.sda_dev_oe <= 1'b1; // R11 R15
                  st <= D_ACK;
                end else begin
                  st <= D_STBY;
                end
              end
            endcase
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            if (kind == K_DEV && rw) begin
              bus.sda_dev_oe <= !rd_byte[7]; // R1 R2
              cnt <= 4'h1;
              st  <= D_TX;
            end else begin
              bus.sda_dev_oe <= 1'b0; // R22
              kind <= (kind == K_DEV) ? K_WADDR : K_DATA;
              st   <= D_RX;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (cnt == BIT_LAST) begin
              bus.sda_dev_oe <= 1'b0; // R22
              cnt <= '0;
              st  <= D_RACK;
            end else begin
              bus.sda_dev_oe <= !rd_byte[~cnt[2:0]]; // R1 R2 R8
              cnt <= cnt + 1'b1;
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            mack <= !lvl[0];
          end else if (scl_fall) begin
            if (mack) begin
              bus.sda_dev_oe <= !rd_byte[7]; // R1
              cnt <= 4'h1;
              st  <= D_TX;
            end else begin
              st <= D_STBY; // R10
            end
          end
        end
      endcase
    end
  end

  // open drain: only the enable ever moves
  always_ff @(posedge clk) begin
    bus.sda_dev_o <= 1'b0; // R2
  end

  assign push = byte_done && (kind == K_DATA) && !lvl[4]; // R5

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
    end else if (st != D_PROG && (start || stop)) begin
      wr_pend <= 1'b0;
    end else if (push && f_iready) begin
      wr_pend <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pg   <= '0;
      addr <= '0;
    end else if (byte_done && kind == K_DEV && dev_hit) begin
      pg <= LARGE ? shreg[2:1] : {1'b0, shreg[1]}; // R6 R7
    end else if (byte_done && kind == K_WADDR) begin
      addr <= {pg, shreg} & amask; // R6 R7
    end else if (byte_done && kind == K_DATA && (f_iready || lvl[4])) begin
      addr <= {addr[ADDR_W-1:PAGE_W], addr[PAGE_W-1:0] + 1'b1}; // R15
    end else if (st == D_TX && scl_fall && cnt == BIT_LAST) begin
      addr <= (addr + 1'b1) & amask;
    end
  end

  // bytes wait here until the stop; the array only changes during the program cycle
  sesp_fifo #(
    .W (FIFO_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst || start && st != D_PROG),
    .in_valid  (push),
    .in_ready  (f_iready),
    .in_data   ({addr, shreg}),
    .out_valid (f_ovalid),
    .out_ready (st == D_PROG),
    .out_data  (f_odata)
  );

  always_ff @(posedge clk) begin
    if (f_ovalid && st == D_PROG) begin
      mem[f_odata[FIFO_W-1:8]] <= f_odata[7:0]; // R14 R15
    end
  end

  always_ff @(posedge clk) begin
    if (srst || st != D_PROG) begin
      tmr <= '0;
    end else if (!tmr_done) begin
      tmr <= tmr + 1'b1; // R14
    end
  end
endmodule // sesp_dev
`default_nettype wire

// file: hw/sesp_host.sv
// two-wire bus master end: scl divider, start/stop framing and byte sequencing
`timescale 1ns/100ps
`default_nettype none
module sesp_host
  import sesp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  sesp_if.host            bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire sesp_op_t   cmd_op,
  input  wire logic [2:0] cmd_dev,
  input  wire logic [7:0] cmd_waddr,
  input  wire logic [4:0] cmd_len,
  input  wire logic [7:0] wr_data,
  output logic            wr_take,
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            done,
  output logic            nack
);
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_START = 9'h002,
    S_DEVW  = 9'h004,
    S_WADDR = 9'h008,
    S_WDATA = 9'h010,
    S_DEVR  = 9'h020,
    S_RDATA = 9'h040,
    S_CLK9  = 9'h080,
    S_STOP  = 9'h100
  } sesp_hst_t;

  sesp_hst_t  stg;
  sesp_op_t   op;
  logic [7:0] qcnt;
  logic       qtick;
  logic [1:0] ph;
  logic [3:0] bi;
  logic [7:0] txb;
  logic [7:0] rxb;
  logic [2:0] dev;
  logic [7:0] wa;
  logic [4:0] left;
  logic       again;
  logic       samp;
  logic       s1;
  logic       s2;
  logic       s3;
  logic       sda_l;
  logic       bend;

  // quarter-period enable; the host makes scl, so no second domain
  always_ff @(posedge clk) begin
    if (srst || qcnt == 8'(QTR_CYC - 1)) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + 1'b1;
    end
  end
  assign qtick = (qcnt == 8'(QTR_CYC - 1)); // R17

  always_ff @(posedge clk) begin
    if (srst) begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      sda_l <= 1'b1;
    end else begin
      s1 <= bus.sda;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sda_l <= s3;
      end
    end
  end

  assign bend = qtick && ph == 2'h3 && bi == BIT_LAST;

  always_ff @(posedge clk) begin
    bus.sda_host_o <= 1'b0; // R2
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stg <= S_IDLE;
      op  <= OP_WRITE;
      ph  <= '0;
      bi  <= '0;
      txb <= '0;
      rxb <= '0;
      dev <= '0;
      wa  <= '0;
      left  <= '0;
      again <= 1'b0;
      samp  <= 1'b1;
      cmd_ready <= 1'b1;
      wr_take   <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
      done <= 1'b0;
      nack <= 1'b0;
      bus.scl <= 1'b1;
      bus.sda_host_oe <= 1'b0;
    end else begin
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      if (stg == S_IDLE) begin
        if (cmd_valid && cmd_ready) begin
          op  <= cmd_op;
          dev <= cmd_dev;
          wa  <= cmd_waddr;
          left  <= cmd_len;
          again <= 1'b0;
          nack  <= 1'b0;
          cmd_ready <= 1'b0;
          ph  <= '0;
          stg <= S_START;
        end
      end else if (qtick) begin
        ph <= ph + 1'b1;
        unique case (stg)
          S_START: begin
            unique case (ph)
              2'h0: bus.sda_host_oe <= 1'b0;
              2'h1: bus.scl <= 1'b1;
              2'h2: bus.sda_host_oe <= 1'b1; // R9
              2'h3: begin
                bus.scl <= 1'b0;
                bi <= '0;
                if (op == OP_RECOVER) begin
                  txb <= 8'hFF;
                  stg <= again ? S_STOP : S_CLK9; // R13
                end else if (again || op == OP_CURREAD) begin
                  txb <= {DEV_CODE, dev, 1'b1}; // R18
                  stg <= S_DEVR;
                end else begin
                  txb <= {DEV_CODE, dev, 1'b0}; // R18 R16
                  stg <= S_DEVW;
                end
              end
            endcase
          end
          S_STOP: begin
            unique case (ph)
              2'h0: bus.sda_host_oe <= 1'b1;
              2'h1: bus.scl <= 1'b1;
              2'h2: bus.sda_host_oe <= 1'b0; // R10
              2'h3: begin
                done <= 1'b1;
                cmd_ready <= 1'b1;
                stg <= S_IDLE;
              end
            endcase
          end
          default: begin
            unique case (ph)
              2'h0: begin
                // scl is low here, so data only moves between clocks
                if (stg == S_RDATA) begin
                  bus.sda_host_oe <= (bi == BIT_LAST) && (left != 5'h1); // R8
                end else begin
                  bus.sda_host_oe <= (bi != BIT_LAST) && !txb[~bi[2:0]]; // R8
                end
              end
              2'h1: bus.scl <= 1'b1;
              2'h2: begin
                if (bi == BIT_LAST) begin
                  samp <= sda_l;
                end else begin
                  rxb <= {rxb[6:0], sda_l};
                end
              end
              2'h3: begin
                bus.scl <= 1'b0;
                bi <= bi + 1'b1;
              end
            endcase
            if (bend) begin
              bi <= '0;
              unique case (stg)
                S_CLK9: begin
                  again <= 1'b1;
                  stg <= S_START; // R13
                end
                S_DEVW: begin
                  nack <= samp;
                  txb <= wa;
                  stg <= samp ? S_STOP : S_WADDR;
                end
                S_WADDR: begin
                  nack <= samp;
                  again <= op != OP_WRITE;
                  txb <= wr_data;
                  wr_take <= !samp && op == OP_WRITE;
                  stg <= samp ? S_STOP : (op == OP_WRITE ? S_WDATA : S_START);
                end
                S_WDATA: begin
                  nack <= samp;
                  left <= left - 1'b1;
                  txb <= wr_data;
                  wr_take <= !samp && left != 5'h1;
                  stg <= (samp || left == 5'h1) ? S_STOP : S_WDATA;
                end
                S_DEVR: begin
                  nack <= samp;
                  stg <= samp ? S_STOP : S_RDATA;
                end
                default: begin
                  rd_valid <= 1'b1;
                  rd_data <= rxb;
                  left <= left - 1'b1;
                  stg <= (left == 5'h1) ? S_STOP : S_RDATA;
                end
              endcase
            end
          end
        endcase
      end
    end
  end
endmodule // sesp_host
`default_nettype wire

// file: shared/sesp_if.sv
// two-wire bus between host end and device end, open-drain data resolved here
`timescale 1ns/100ps
`default_nettype none
interface sesp_if;
  logic scl;
  logic sda;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;

  // wired-and with pull-up: any enabled low driver wins
  assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

// file: shared/sesp_pkg.sv
// constants and types shared by both ends of the serial eeprom link
package sesp_pkg;
  localparam int CLK_NS     = 4;
  localparam int TWR_MS     = 5;
  localparam int TWR_CYC    = TWR_MS * 1000000 / CLK_NS;
  localparam int SCL_NS     = 2500;
  localparam int QTR_CYC    = SCL_NS / (4 * CLK_NS);
  localparam int ADDR_W     = 10;
  localparam int PAGE_W     = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W     = ADDR_W + 8;
  localparam int MEM_BYTES  = 1024;
  localparam logic [3:0] DEV_CODE  = 4'hA;
  localparam logic [3:0] BIT_LAST  = 4'h8;
  localparam logic [4:0] SYNC_RST  = 5'h03;
  localparam logic [ADDR_W-1:0] AMASK_SMALL = 10'h1FF;
  localparam logic [ADDR_W-1:0] AMASK_LARGE = 10'h3FF;

  typedef enum logic [1:0] {
    OP_WRITE   = 2'h0,
    OP_READ    = 2'h1,
    OP_CURREAD = 2'h2,
    OP_RECOVER = 2'h3
  } sesp_op_t;
endpackage

// file: verif/sesp_checker.sv
// concurrent checks on the two-wire link between the host end and the device end
`timescale 1ns/100ps
`default_nettype none
module sesp_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  logic       scl_q;
  logic       sda_q;
  logic       in_frame;
  logic       first_byte;
  logic [3:0] bit_n;
  logic       start_ev;
  logic       stop_ev;
  logic       scl_rise;

  // raw pins, so a slow synchroniser in the device cannot hide a late release
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign scl_rise = scl && !scl_q;

  always_ff @(posedge clk) begin
    scl_q <= srst ? 1'h1 : scl;
    sda_q <= srst ? 1'h1 : sda;
  end

  always_ff @(posedge clk) begin
    if (srst || start_ev) begin
      bit_n      <= 4'h0;
      first_byte <= 1'h1;
    end else if (scl_rise) begin
      bit_n <= (bit_n == 4'h9) ? 4'h1 : bit_n + 4'h1;
      if (bit_n == 4'h8) first_byte <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || stop_ev) in_frame <= 1'h0;
    else if (start_ev) in_frame <= 1'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  dev_open_drain_a: assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("device drives data line high");
  host_open_drain_a: assert property (sda_host_oe |-> !sda_host_o)
    else $error("host drives data line high");
  no_fight_a: assert property (scl_rise |-> !(sda_dev_oe && sda_host_oe))
    else $error("both ends pull data at a clock rise");
  dev_word_quiet_a: assert property (scl_rise && first_byte && bit_n < 4'h8 |-> !sda_dev_oe)
    else $error("device drives during the device word");
  launch_low_a: assert property ($rose(sda_dev_oe) |-> !scl && !$past(scl))
    else $error("device launch not after clock fall");
  ack_hold_a: assert property ($rose(sda_dev_oe) |=> sda_dev_oe [*8])
    else $error("device pull dropped too soon");
  release_low_a: assert property ($fell(sda_dev_oe) |-> !scl)
    else $error("device released data while clock high");
  start_hold_a: assert property (start_ev |-> scl [*8])
    else $error("clock fell right after start");
  in_frame_a: assert property ($fell(scl) |-> in_frame)
    else $error("clock toggled outside a frame");
  stop_quiet_a: assert property (stop_ev |=> !sda_dev_oe [*8])
    else $error("device drives after stop");
endmodule // sesp_checker
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench: host end and device end joined over the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module testbench
  import sesp_pkg::*;
;
  // program must outlast the poll's start yet end before the strap-mismatch command
  localparam int TWR = 4000;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic        cmd_valid, cmd_ready, wr_take, rd_valid, done, nack, upper, lower, wg;
  sesp_op_t    cmd_op;
  logic [2:0]  cmd_dev;
  logic [4:0]  cmd_len;
  logic [7:0]  cmd_waddr, wr_data, rd_data, wsh;
  logic        scl_p, sda_p;
  logic [31:0] seed = 32'hFFF9C4A2;
  logic [7:0]  mem [int];
  logic [7:0]  wq [$];
  logic [7:0]  rq [$];
  int          wcnt, err_count, checked;

  always #2 clk = ~clk;

  sesp_if bus ();
  sesp_host u_sesp_host (.clk(clk), .srst(srst), .bus(bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_dev(cmd_dev), .cmd_waddr(cmd_waddr), .cmd_len(cmd_len), .wr_data(wr_data),
    .wr_take(wr_take), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
  sesp_dev #(.LARGE(1'h0), .TWR_CYCLES(TWR)) u_sesp_dev (.clk(clk), .srst(srst), .bus(bus),
    .strap_select_upper(upper), .strap_select_lower(lower), .unused_strap_input(1'h0), .write_guard(wg));
  sesp_checker u_sesp_checker (.clk(clk), .srst(srst), .scl(bus.scl), .sda(bus.sda), .sda_host_o(bus.sda_host_o),
    .sda_host_oe(bus.sda_host_oe), .sda_dev_o(bus.sda_dev_o), .sda_dev_oe(bus.sda_dev_oe));

  // first eight bits after each start, as seen on the wire
  always @(posedge clk) begin
    scl_p <= bus.scl;
    sda_p <= bus.sda;
    if (bus.scl && scl_p && sda_p && !bus.sda) wcnt <= 0;
    else if (bus.scl && !scl_p && wcnt < 8) begin
      wsh  <= {wsh[6:0], bus.sda};
      wcnt <= wcnt + 1;
    end
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // model updates first, so expectations never come from the design
  task automatic run_cmd(input sesp_op_t op, input logic [2:0] dv, input logic [7:0] wa,
                         input logic [4:0] ln, input logic exp_nack, input bit cn);
    int         n;
    int         nrd;
    int         ntk;
    logic [8:0] base;
    nrd  = 0;
    ntk  = 0;
    base = {dv[0], wa};
    if (op == OP_WRITE && !wg && !exp_nack)
      for (int i = 0; i < ln; i++) mem[{base[8:4], 4'(base[3:0] + i)}] = wq[i];
    if (op == OP_READ)
      for (int i = 0; i < ln; i++) rq.push_back(mem[(base + i) % 512]);
    @(negedge clk);
    check(cmd_ready, 1'h1);
    cmd_valid = 1'h1;
    cmd_op    = op;
    cmd_dev   = dv;
    cmd_waddr = wa;
    cmd_len   = ln;
    if (wq.size() > 0) wr_data = wq.pop_front();
    @(negedge clk);
    cmd_valid = 1'h0;
    for (n = 0; n < 40000 && done !== 1'h1; n++) begin
      @(negedge clk);
      if (wr_take === 1'h1) ntk++;
      if (wr_take === 1'h1 && wq.size() > 0) wr_data = wq.pop_front();
      if (rd_valid === 1'h1) nrd++;
      if (rd_valid === 1'h1) check(rd_data, rq.pop_front());
    end
    if (n == 40000) begin
      err_count++;
      final_report;
    end
    if (cn) check(nack, exp_nack);
    check(rq.size() + wq.size(), 0);
    check(ntk, (op == OP_WRITE && !exp_nack) ? ln : 5'h00);
    check(nrd, (op != OP_WRITE && op != OP_RECOVER && !exp_nack) ? ln : 5'h00);
    check(bus.sda_dev_oe, 1'h0);
  endtask

  initial begin
    cmd_valid = 1'h0;
    cmd_op = OP_WRITE;
    cmd_dev = 3'h0;
    cmd_waddr = 8'h00;
    cmd_len = 5'h01;
    wr_data = 8'h00;
    wg = 1'h0;
    wcnt = 0;
    wsh = 8'h00;
    upper = seed[0];
    lower = seed[1];
    repeat (8) @(posedge clk);
    @(negedge clk);
    srst = 1'h0;
    // three bytes from the last page byte: the second wraps to the page start
    repeat (3) begin
      seed = next_rand(seed);
      wq.push_back(seed[7:0]);
    end
    run_cmd(OP_WRITE, {upper, lower, 1'h1}, 8'hFF, 5'h03, 1'h0, 1'h1);
    check(wsh, {4'hA, upper, lower, 1'h1, 1'h0});
    run_cmd(OP_CURREAD, {upper, lower, 1'h0}, 8'h00, 5'h01, 1'h1, 1'h1);
    run_cmd(OP_CURREAD, {~upper, lower, 1'h0}, 8'h00, 5'h01, 1'h1, 1'h1);
    check(wsh, {4'hA, ~upper, lower, 1'h0, 1'h1});
    run_cmd(OP_RECOVER, 3'h0, 8'h00, 5'h01, 1'h0, 1'h0);
    wg = 1'h1;
    wq.push_back(~mem[9'h1F1]);
    run_cmd(OP_WRITE, {upper, lower, 1'h1}, 8'hF1, 5'h01, 1'h0, 1'h1);
    run_cmd(OP_READ, {upper, lower, 1'h1}, 8'hF0, 5'h02, 1'h0, 1'h1);
    check({bus.scl, bus.sda}, 2'h3);
    final_report;
  end

  // a clean run needs just under 100000 cycles of bus traffic
  initial begin
    repeat (110000) @(posedge clk);
    err_count++;
    final_report;
  end
endmodule // testbench
`default_nettype wire
